// File: inc/adc_pkg.sv
// Shared constants, register map and encodings of the converter output control
package adc_pkg;

  localparam int unsigned DATA_W        = 12;
  localparam int unsigned PIPE_DEPTH    = 5;
  localparam int unsigned SYNC_W        = 15;
  localparam int unsigned SYNC_OOR_BIT  = 12;
  localparam int unsigned SYNC_SCLK_BIT = 13;
  localparam int unsigned SYNC_PD_BIT   = 14;

  // System clock and standby threshold
  localparam int unsigned CLK_PERIOD_NS  = 4;
  localparam int unsigned CLK_HZ         = 1000000000 / CLK_PERIOD_NS;
  localparam int unsigned STANDBY_HZ_DEF = 20000000;
  localparam int unsigned STANDBY_HZ_ALT = 1000000;
  localparam int unsigned PERIOD_W       = 16;
  localparam logic [15:0] PERIOD_MAX     = 16'hFFFF;

  // Sample edges the stabilizer loop waits after a rate change
  localparam int unsigned RELOCK_EDGES = 64;
  localparam logic [7:0]  RELOCK_LAST  = 8'(RELOCK_EDGES - 1);

  // Register map
  localparam int unsigned ADDR_W      = 8;
  localparam logic [7:0]  OFS_STATUS  = 8'h00;
  localparam logic [7:0]  OFS_CLEAR   = 8'h04;
  localparam logic [7:0]  OFS_ENABLE  = 8'h08;
  localparam logic [7:0]  OFS_CONFIG  = 8'h0C;
  localparam logic [7:0]  OFS_STATE   = 8'h10;

  // Event bits of status, clear and enable
  localparam int unsigned EV_W      = 4;
  localparam int unsigned EV_OOR    = 0;
  localparam int unsigned EV_STBY   = 1;
  localparam int unsigned EV_RESUME = 2;
  localparam int unsigned EV_LOCK   = 3;

  // Configuration fields
  localparam int unsigned CFG_W       = 3;
  localparam int unsigned CFG_FMT_LSB = 0;
  localparam int unsigned CFG_DCS_BIT = 2;
  localparam logic [2:0]  CFG_RESET   = 3'h4;
  localparam logic [3:0]  ENABLE_RESET = 4'h0;

  // State read-back fields
  localparam int unsigned ST_LOCK_BIT   = 2;
  localparam int unsigned ST_SLOW_BIT   = 3;
  localparam int unsigned ST_PD_BIT     = 4;
  localparam int unsigned ST_PERIOD_LSB = 16;

  typedef enum logic [1:0] {
    FMT_OFFSET = 2'b00,
    FMT_TWOS   = 2'b01,
    FMT_GRAY   = 2'b10
  } fmt_e;

  typedef enum logic [1:0] {
    ST_STANDBY = 2'b00,
    ST_FILL    = 2'b01,
    ST_RUN     = 2'b10
  } run_e;

endpackage

// File: inc/clk_mon_if.sv
// Link between the output core and the sample clock monitor
`timescale 1ns/1ps
interface clk_mon_if;
  logic        sclk;
  logic        dcs_en;
  logic        edge_p;
  logic        slow;
  logic        locked;
  logic        lock_done;
  logic        data_clock_out;
  logic [15:0] period;

  modport mon (
    input  sclk,
    input  dcs_en,
    output edge_p,
    output slow,
    output locked,
    output lock_done,
    output data_clock_out,
    output period
  );

  modport core (
    output sclk,
    output dcs_en,
    input  edge_p,
    input  slow,
    input  locked,
    input  lock_done,
    input  data_clock_out,
    input  period
  );
endinterface

// File: hdl/clk_monitor.sv
// Sample clock edge finder, rate monitor, stabilizer loop and data clock generator
`timescale 1ns/1ps
module clk_monitor #(
  parameter int unsigned SLOW_LIMIT = 12
) (
  input wire logic clk,
  input wire logic rst,
  clk_mon_if.mon   mon
);

  localparam logic [15:0] SLOW_L = 16'(SLOW_LIMIT);

  logic        sclk_d_reg;
  logic [15:0] cnt_reg;
  logic [15:0] period_reg;
  logic        slow_reg;
  logic [7:0]  lock_cnt_reg;
  logic        locked_reg;
  logic        lock_done_reg;
  logic        dco_reg;
  logic [15:0] period_new;
  logic [15:0] half;
  logic        edge_p;
  logic        chg;

  assign edge_p     = mon.sclk & ~sclk_d_reg;
  assign period_new = cnt_reg + 16'h0001;
  assign half       = period_reg >> 1;
  // A drift of one system cycle is sampling jitter, not a rate change
  assign chg = edge_p && ((period_new > period_reg + 16'h0001) ||
                          (period_new + 16'h0001 < period_reg));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_d_reg <= 1'b0;
    end else begin
      sclk_d_reg <= mon.sclk;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg    <= adc_pkg::PERIOD_MAX;
      period_reg <= adc_pkg::PERIOD_MAX;
    end else if (edge_p) begin
      cnt_reg    <= 16'h0000;
      period_reg <= period_new;
    end else if (cnt_reg != adc_pkg::PERIOD_MAX) begin
      cnt_reg <= period_new;
    end
  end

  // Starts slow: no clock is assumed until edges prove the rate
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slow_reg <= 1'b1;
    end else if (cnt_reg >= SLOW_L) begin
      slow_reg <= 1'b1;
    end else if (edge_p) begin
      slow_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lock_cnt_reg  <= 8'h00;
      locked_reg    <= 1'b0;
      lock_done_reg <= 1'b0;
    end else begin
      lock_done_reg <= 1'b0;
      if (slow_reg || chg) begin
        lock_cnt_reg <= 8'h00;
        locked_reg   <= 1'b0;
      end else if (edge_p && !locked_reg) begin
        if (lock_cnt_reg == adc_pkg::RELOCK_LAST) begin
          locked_reg    <= 1'b1;
          lock_done_reg <= 1'b1;
        end else begin
          lock_cnt_reg <= lock_cnt_reg + 8'h01;
        end
      end
    end
  end

  // Data change at the sampling edge, so the data clock rises mid-period
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dco_reg <= 1'b0;
    end else if (!mon.dcs_en) begin
      dco_reg <= ~mon.sclk;
    end else if (edge_p) begin
      dco_reg <= 1'b0;
    end else if (period_new == half) begin
      dco_reg <= 1'b1;
    end
  end

  assign mon.edge_p    = edge_p;
  assign mon.slow      = slow_reg;
  assign mon.locked    = locked_reg;
  assign mon.lock_done = lock_done_reg;
  assign mon.data_clock_out       = dco_reg;
  assign mon.period    = period_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_slow_entry: assert property ((cnt_reg == SLOW_L) |=> slow_reg)
    else $error("slow clock did not raise standby");
  a_relock_drop: assert property (chg |=> !locked_reg && lock_cnt_reg == 8'h00)
    else $error("rate change did not restart stabilizer lock");
  a_dcs_regen: assert property (mon.dcs_en && edge_p |=> !dco_reg)
    else $error("regenerated clock not low after sampling edge");

endmodule

// File: hdl/adc_output_ctrl.sv
// Output side of the sampling converter: pipeline, coding, flag, standby, registers
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
module adc_output_ctrl #(
  // Threshold disputed between 20 MHz and 1 MSPS; default keeps the 20 MHz figure
  parameter int unsigned STANDBY_HZ = adc_pkg::STANDBY_HZ_DEF
) (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        SAMPLE_CLK,
  input  wire logic [11:0] SAMPLE_IN,
  input  wire logic        SAMPLE_OOR,
  input  wire logic        POWER_DOWN_PIN,
  output logic      [11:0] DATA_OUT,
  output logic             OUT_OF_RANGE_FLAG,
  output logic             DATA_CLOCK_OUT,
  output logic             DRIVER_OE,
  output logic             OUT_VALID,
  output logic             STANDBY,
  output logic             DLL_LOCKED,
  output logic             IRQ,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [31:0] REG_RDATA
);

  localparam int unsigned SLOW_LIMIT = adc_pkg::CLK_HZ / STANDBY_HZ;
  localparam int unsigned DW         = adc_pkg::DATA_W;
  localparam int unsigned PD         = adc_pkg::PIPE_DEPTH;
  localparam logic [2:0]  FILL_LAST  = 3'(adc_pkg::PIPE_DEPTH);

  function automatic logic [11:0] encode(input logic [11:0] code, input logic [1:0] fmt);
    logic [11:0] r;
    r = code;
    case (fmt)
      adc_pkg::FMT_OFFSET: r = code;
      adc_pkg::FMT_TWOS:   r = {~code[11], code[10:0]};
      adc_pkg::FMT_GRAY:   r = code ^ (code >> 1);
      default:             r = code;
    endcase
    return r;
  endfunction

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    return addr == ofs;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [14:0] sync1_reg;
  logic [14:0] sync2_reg;
  logic        pd;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sync1_reg <= 15'h0000;
      sync2_reg <= 15'h0000;
    end else begin
      sync1_reg <= {POWER_DOWN_PIN, SAMPLE_CLK, SAMPLE_OOR, SAMPLE_IN};
      sync2_reg <= sync1_reg;
    end
  end

  assign pd = sync2_reg[adc_pkg::SYNC_PD_BIT];

  //////////////////////////////////////////////////////////////////////////////
  // Clock monitor

  clk_mon_if mon_if ();
  logic [2:0] config_reg;

  assign mon_if.sclk   = sync2_reg[adc_pkg::SYNC_SCLK_BIT];
  assign mon_if.dcs_en = config_reg[adc_pkg::CFG_DCS_BIT];

  clk_monitor #(
    .SLOW_LIMIT (SLOW_LIMIT)
  ) u_mon (
    .clk (CLK),
    .rst (RST),
    .mon (mon_if.mon)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Run state

  adc_pkg::run_e run_state_reg;
  adc_pkg::run_e run_state_next;
  logic [2:0]    fill_cnt_reg;
  logic          idle_req;
  logic          shift;

  // Both standby causes stop the pipeline and release the drivers
  assign idle_req = pd || mon_if.slow;
  assign shift    = mon_if.edge_p && (run_state_reg != adc_pkg::ST_STANDBY);

  always_comb begin
    run_state_next = run_state_reg;
    case (run_state_reg)
      adc_pkg::ST_STANDBY: begin
        if (!idle_req) begin
          run_state_next = adc_pkg::ST_FILL;
        end
      end
      adc_pkg::ST_FILL: begin
        if (idle_req) begin
          run_state_next = adc_pkg::ST_STANDBY;
        end else if (mon_if.edge_p && fill_cnt_reg == FILL_LAST) begin
          run_state_next = adc_pkg::ST_RUN;
        end
      end
      adc_pkg::ST_RUN: begin
        if (idle_req) begin
          run_state_next = adc_pkg::ST_STANDBY;
        end
      end
      default: run_state_next = adc_pkg::ST_STANDBY;
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      run_state_reg <= adc_pkg::ST_STANDBY;
    end else begin
      run_state_reg <= run_state_next;
    end
  end

  // Counts edges until a freshly sampled word reaches the output register
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      fill_cnt_reg <= 3'h0;
    end else if (run_state_reg != adc_pkg::ST_FILL) begin
      fill_cnt_reg <= 3'h0;
    end else if (mon_if.edge_p) begin
      fill_cnt_reg <= fill_cnt_reg + 3'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sample pipeline: flag bit rides above the code

  logic [12:0] pipe_reg [PD];
  logic [11:0] data_out_reg;
  logic        oor_out_reg;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pipe_reg[0] <= 13'h0000;
    end else if (shift) begin
      pipe_reg[0] <= sync2_reg[12:0];
    end
  end

  genvar g;
  generate
    for (g = 1; g < PD; g++) begin : g_stage
      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          pipe_reg[g] <= 13'h0000;
        end else if (shift) begin
          pipe_reg[g] <= pipe_reg[g-1];
        end
      end
    end
  endgenerate

  // Flag is per sample, so it clears with the first in-range word
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      data_out_reg <= 12'h000;
      oor_out_reg  <= 1'b0;
    end else if (shift) begin
      data_out_reg <= encode(pipe_reg[PD-1][11:0], config_reg[1:0]);
      oor_out_reg  <= pipe_reg[PD-1][adc_pkg::SYNC_OOR_BIT];
    end
  end

  assign DATA_OUT          = data_out_reg;
  assign OUT_OF_RANGE_FLAG = oor_out_reg;
  assign DATA_CLOCK_OUT    = mon_if.data_clock_out;
  assign DRIVER_OE         = (run_state_reg != adc_pkg::ST_STANDBY);
  assign OUT_VALID         = (run_state_reg == adc_pkg::ST_RUN);
  assign STANDBY           = (run_state_reg == adc_pkg::ST_STANDBY);
  assign DLL_LOCKED        = mon_if.locked;

  //////////////////////////////////////////////////////////////////////////////
  // Events and registers

  logic [3:0]  status_reg;
  logic [3:0]  enable_reg;
  logic [3:0]  events;
  logic [3:0]  clr;
  logic [31:0] rdata_reg;
  logic [31:0] state_word;

  always_comb begin
    events = 4'h0;
    events[adc_pkg::EV_OOR]    = shift && pipe_reg[PD-1][adc_pkg::SYNC_OOR_BIT];
    events[adc_pkg::EV_STBY]   = (run_state_reg != adc_pkg::ST_STANDBY) &&
                                 (run_state_next == adc_pkg::ST_STANDBY);
    events[adc_pkg::EV_RESUME] = (run_state_reg == adc_pkg::ST_FILL) &&
                                 (run_state_next == adc_pkg::ST_RUN);
    events[adc_pkg::EV_LOCK]   = mon_if.lock_done;
  end

  assign clr = (REG_WR && hit(REG_ADDR, adc_pkg::OFS_CLEAR)) ? REG_WDATA[3:0] : 4'h0;

  // A new event beats a clear in the same cycle
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      status_reg <= 4'h0;
    end else begin
      status_reg <= (status_reg & ~clr) | events;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      enable_reg <= adc_pkg::ENABLE_RESET;
      config_reg <= adc_pkg::CFG_RESET;
    end else if (REG_WR) begin
      if (hit(REG_ADDR, adc_pkg::OFS_ENABLE)) begin
        enable_reg <= REG_WDATA[3:0];
      end
      if (hit(REG_ADDR, adc_pkg::OFS_CONFIG)) begin
        config_reg <= REG_WDATA[2:0];
      end
    end
  end

  always_comb begin
    state_word = 32'h0000_0000;
    state_word[1:0] = run_state_reg;
    state_word[adc_pkg::ST_LOCK_BIT] = mon_if.locked;
    state_word[adc_pkg::ST_SLOW_BIT] = mon_if.slow;
    state_word[adc_pkg::ST_PD_BIT]   = pd;
    state_word[31:16] = mon_if.period;
  end

  // Read data live for one cycle only; unmapped and write-only read zero
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rdata_reg <= 32'h0000_0000;
    end else if (!REG_RD) begin
      rdata_reg <= 32'h0000_0000;
    end else if (hit(REG_ADDR, adc_pkg::OFS_STATUS)) begin
      rdata_reg <= {28'h0000000, status_reg};
    end else if (hit(REG_ADDR, adc_pkg::OFS_ENABLE)) begin
      rdata_reg <= {28'h0000000, enable_reg};
    end else if (hit(REG_ADDR, adc_pkg::OFS_CONFIG)) begin
      rdata_reg <= {29'h00000000, config_reg};
    end else if (hit(REG_ADDR, adc_pkg::OFS_STATE)) begin
      rdata_reg <= state_word;
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  assign REG_RDATA = rdata_reg;
  assign IRQ       = |(status_reg & enable_reg);

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_filled;
    mon_if.edge_p && run_state_reg == adc_pkg::ST_FILL && fill_cnt_reg == FILL_LAST;
  endsequence

  a_pd_standby: assert property (pd |=> STANDBY && !OUT_VALID)
    else $error("power-down did not force standby");
  a_pd_hiz: assert property (pd |=> !DRIVER_OE [*2] or !pd)
    else $error("drivers enabled during power-down");
  a_pd_resume: assert property (STANDBY && !pd && !mon_if.slow |=> DRIVER_OE && !OUT_VALID)
    else $error("no return from standby");
  a_fill_latency: assert property ($rose(OUT_VALID) |-> $past(fill_cnt_reg) == FILL_LAST)
    else $error("output marked valid before pipeline filled");
  a_fill_run: assert property (s_filled and !idle_req |=> OUT_VALID)
    else $error("filled pipeline did not resume output");
  a_flag_align: assert property (shift |=> OUT_OF_RANGE_FLAG == $past(pipe_reg[PD-1][12])
                                 && DATA_OUT == encode($past(pipe_reg[PD-1][11:0]),
                                                       $past(config_reg[1:0])))
    else $error("range flag not aligned with its data word");
  a_offset_code: assert property (shift && config_reg[1:0] == adc_pkg::FMT_OFFSET
                                  |=> DATA_OUT == $past(pipe_reg[PD-1][11:0]))
    else $error("offset binary word wrong");
  a_twos_code: assert property (shift && config_reg[1:0] == adc_pkg::FMT_TWOS
                                |=> DATA_OUT[11] != $past(pipe_reg[PD-1][11]))
    else $error("twos complement sign wrong");
  a_gray_code: assert property (shift && config_reg[1:0] == adc_pkg::FMT_GRAY
                                |=> DATA_OUT == ($past(pipe_reg[PD-1][11:0]) ^
                                                 ($past(pipe_reg[PD-1][11:0]) >> 1)))
    else $error("gray word wrong");
  a_slow_stops: assert property (mon_if.slow |=> STANDBY)
    else $error("slow clock did not stop conversion");

endmodule

// File: tb/lvds_capture_model.sv
// Receiver side model: captures the output word on the data clock rise
`timescale 1ns/1ps
module lvds_capture_model (
  input  wire logic        data_clock_out,
  input  wire logic        oe,
  input  wire logic [11:0] data,
  input  wire logic        flag,
  output logic      [11:0] cap_data,
  output logic             cap_flag,
  output logic             over,
  output logic             under
);
  // Released drivers float and are not captured; stale words driven during refill still are
  wire [11:0] data_line = oe ? data : 12'hZZZ;
  wire        flag_line = oe ? flag : 1'bz;

  initial begin
    cap_data = 12'h000;
    cap_flag = 1'b0;
  end

  always @(posedge data_clock_out) begin
    if (oe === 1'b1) begin
      cap_data <= data_line;
      cap_flag <= flag_line;
    end
  end

  assign over  = cap_flag & cap_data[11];
  assign under = cap_flag & ~cap_data[11];
endmodule

// File: tb/adc_output_ctrl_tb.sv
// Self-checking bench of the converter output control block
`timescale 1ns/1ps
module adc_output_ctrl_tb;
  logic        clk, rst, sample_clk, sample_oor, pd, reg_wr, reg_rd, sclk_run;
  logic [11:0] sample_in, data_out, cap_data;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic        oor_flag, data_clock_out, oe, valid, stby, locked, irq, cap_flag, over, under;
  int          bad_count, cmp_count, cyc, hi;

  typedef struct {
    logic [1:0]  fmt;
    logic [11:0] in;
    logic        oor;
    logic [11:0] exp;
    logic        flag;
  } row_s;
  row_s rows[12] = '{
    '{2'h0, 12'h000, 1'b0, 12'h000, 1'b0}, '{2'h0, 12'h800, 1'b0, 12'h800, 1'b0},
    '{2'h0, 12'hFFF, 1'b0, 12'hFFF, 1'b0}, '{2'h1, 12'h800, 1'b0, 12'h000, 1'b0},
    '{2'h1, 12'hFFF, 1'b0, 12'h7FF, 1'b0}, '{2'h1, 12'h000, 1'b0, 12'h800, 1'b0},
    '{2'h2, 12'h800, 1'b0, 12'hC00, 1'b0}, '{2'h2, 12'h5A5, 1'b0, 12'h777, 1'b0},
    '{2'h3, 12'h123, 1'b0, 12'h123, 1'b0}, '{2'h0, 12'hFFF, 1'b1, 12'hFFF, 1'b1},
    '{2'h0, 12'h000, 1'b1, 12'h000, 1'b1}, '{2'h0, 12'h7FF, 1'b0, 12'h7FF, 1'b0}};

  adc_output_ctrl #(.STANDBY_HZ(adc_pkg::STANDBY_HZ_ALT)) DUT (
    .CLK(clk), .RST(rst), .SAMPLE_CLK(sample_clk), .SAMPLE_IN(sample_in),
    .SAMPLE_OOR(sample_oor), .POWER_DOWN_PIN(pd), .DATA_OUT(data_out),
    .OUT_OF_RANGE_FLAG(oor_flag), .DATA_CLOCK_OUT(data_clock_out), .DRIVER_OE(oe),
    .OUT_VALID(valid), .STANDBY(stby), .DLL_LOCKED(locked), .IRQ(irq),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata));

  lvds_capture_model RX (
    .data_clock_out(data_clock_out), .oe(oe), .data(data_out), .flag(oor_flag), .cap_data(cap_data),
    .cap_flag(cap_flag), .over(over), .under(under));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Sample clock unrelated in phase to the system clock; stands low when stopped
  initial begin
    sample_clk = 1'b0;
    #7.3;
    forever begin
      if (sclk_run) begin
        #62.5 sample_clk = 1'b1;
        #62.5 sample_clk = 1'b0;
      end else begin
        #62.5;
      end
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      $display("ERROR %0t timeout", $time);
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t %s got %b exp %b", $time, msg, got, exp);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  // New value lands after a fall, so it is stable around the next rise
  task automatic put_sample(input logic [11:0] v, input logic o);
    @(negedge sample_clk);
    @(posedge clk);
    sample_in  <= v;
    sample_oor <= o;
  endtask

  task automatic wait_rises(input int n);
    repeat (n) @(posedge sample_clk);
    repeat (10) @(posedge clk);
  endtask

  initial begin
    rst = 1'b1; pd = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; sclk_run = 1'b1;
    sample_in = 12'h800; sample_oor = 1'b0; reg_addr = 8'h00; reg_wdata = 32'h0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    reg_read(adc_pkg::OFS_CONFIG, d); chk_val(d, 32'h4, "config reset");
    reg_read(adc_pkg::OFS_ENABLE, d); chk_val(d, 32'h0, "enable reset");
    reg_read(8'h20, d); chk_val(d, 32'h0, "unmapped read");
    wait_rises(10);
    chk_bit(valid, 1'b1, "valid after start");
    reg_read(adc_pkg::OFS_STATE, d); chk_val(d & 32'h3, 32'h2, "state run");
    foreach (rows[i]) begin
      reg_write(adc_pkg::OFS_CONFIG, {29'h0, 1'b1, rows[i].fmt});
      put_sample(rows[i].in, rows[i].oor);
      wait_rises(7);
      chk_val({20'h0, data_out}, {20'h0, rows[i].exp}, "coded word");
      chk_bit(oor_flag, rows[i].flag, "range flag");
      chk_val({20'h0, cap_data}, {20'h0, rows[i].exp}, "captured word");
      chk_bit(over, rows[i].flag & rows[i].exp[11], "over range");
      chk_bit(under, rows[i].flag & ~rows[i].exp[11], "under range");
    end
    // Latency: word and flag must both move on the fifth edge, not the fourth
    put_sample(12'hABC, 1'b1);
    @(posedge sample_clk);
    wait_rises(4);
    chk_val({20'h0, data_out}, 32'h7FF, "word early");
    chk_bit(oor_flag, 1'b0, "flag early");
    wait_rises(1);
    chk_val({20'h0, data_out}, 32'hABC, "word on time");
    chk_bit(oor_flag, 1'b1, "flag on time");
    put_sample(12'h800, 1'b0);
    wait_rises(7);
    chk_bit(locked, 1'b1, "loop locked");
    reg_read(adc_pkg::OFS_STATUS, d); chk_bit(d[3], 1'b1, "lock event");
    // Stabilizer on, then off; the second write restores it
    for (int k = 0; k < 2; k++) begin
      hi = 0;
      @(posedge sample_clk);
      repeat (31) begin
        @(posedge clk);
        if (data_clock_out === 1'b1) hi++;
      end
      chk_bit(hi >= 13 && hi <= 18, 1'b1, "data clock duty");
      reg_write(adc_pkg::OFS_CONFIG, {29'h0, k[0], 2'h0});
    end
    // Interrupt: clear, enable, raise, mask, unmask, clear
    reg_write(adc_pkg::OFS_CLEAR, 32'hF);
    reg_write(adc_pkg::OFS_ENABLE, 32'h1);
    reg_read(adc_pkg::OFS_STATUS, d); chk_bit(d[0], 1'b0, "status cleared");
    chk_bit(irq, 1'b0, "irq idle");
    put_sample(12'hFFF, 1'b1);
    wait_rises(7);
    chk_bit(irq, 1'b1, "irq raised");
    reg_write(adc_pkg::OFS_ENABLE, 32'h0);
    @(posedge clk); chk_bit(irq, 1'b0, "irq masked");
    reg_write(adc_pkg::OFS_ENABLE, 32'h1);
    @(posedge clk); chk_bit(irq, 1'b1, "irq unmasked");
    put_sample(12'h800, 1'b0);
    wait_rises(7);
    reg_write(adc_pkg::OFS_CLEAR, 32'h1);
    @(posedge clk); chk_bit(irq, 1'b0, "irq cleared");
    // Power-down pin
    @(posedge clk) pd <= 1'b1;
    repeat (10) @(posedge clk);
    chk_bit(stby, 1'b1, "pd standby");
    chk_bit(oe, 1'b0, "pd drivers off");
    chk_bit(valid, 1'b0, "pd not valid");
    reg_read(adc_pkg::OFS_STATE, d); chk_val(d & 32'h1B, 32'h10, "pd state");
    @(posedge clk) pd <= 1'b0;
    wait_rises(4);
    chk_bit(valid, 1'b0, "pd refill");
    wait_rises(6);
    chk_bit(valid, 1'b1, "pd resumed");
    chk_bit(oe, 1'b1, "pd drivers on");
    chk_val({20'h0, data_out}, 32'h800, "pd word");
    reg_read(adc_pkg::OFS_STATUS, d); chk_val(d & 32'h6, 32'h6, "pd events");
    // Clock stop below threshold, then restart
    sclk_run = 1'b0;
    repeat (400) @(posedge clk);
    chk_bit(stby, 1'b1, "slow standby");
    chk_bit(oe, 1'b0, "slow drivers off");
    chk_bit(locked, 1'b0, "slow unlock");
    sclk_run = 1'b1;
    wait_rises(4);
    chk_bit(valid, 1'b0, "restart refill");
    wait_rises(8);
    chk_bit(valid, 1'b1, "restart resumed");
    chk_val({20'h0, data_out}, 32'h800, "restart word");
    // Reset in mid-run: idle values, then a clean refill
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    chk_bit(stby, 1'b1, "reset standby");
    chk_bit(oe, 1'b0, "reset drivers off");
    chk_bit(locked, 1'b0, "reset unlock");
    chk_bit(irq, 1'b0, "reset irq");
    chk_val({20'h0, data_out}, 32'h0, "reset word");
    rst <= 1'b0;
    reg_read(adc_pkg::OFS_CONFIG, d); chk_val(d, 32'h4, "config after reset");
    wait_rises(10);
    chk_bit(valid, 1'b1, "valid after reset");
    chk_val({20'h0, data_out}, 32'h800, "word after reset");
    end_of_test();
  end
endmodule
